// ===== hw/pcrb_register_bank.sv
// Configuration and revision registers of the power module command layer
`timescale 1ns/10ps
`default_nettype none
`include "pcrb_params.svh"

// Overview of operation
// - Revision register is read with read byte; one data byte answers.
// - Revision upper nibble always reads 0011 for part one, revision 1.3.
// - Revision lower nibble always reads 0011 for part two, revision 1.3.
// - Compensation bit 4 picks feed-forward capacitor: 0 is 20pF, 1 is 50pF.
// - Compensation bits 3..1 pick single-phase ramp from 5.6 to 44 mV.
// - With multi-phase set, ramp codes pick 8.6 to 68 mV after the first enabled clock; reset loads the single-phase value.
// - Compensation bit 0 low enables slave-phase fault detection, high disables.
// - Reserved bits of both control registers store and return written values.
// - Output bit 6 high discharges output at control-pin low or off command.
// - Output bits 5..2 set power-good delay: 2, 3 ... 16 ms, top code 1 ms.
// - Output bits 1..0 pick external divider or one of three internal ranges.
module pcrb_register_bank #(
  parameter logic [7:0] COMP_RESET = `PCRB_RESET_BYTE,
  parameter logic [7:0] VOUT_RESET = `PCRB_RESET_BYTE
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               ce,
  input  wire pcrb_pkg::pcrb_req_t req,
  input  wire logic               multiPhase,
  input  wire logic               ctrlPinLow,
  input  wire logic               offCommand,
  output var  pcrb_pkg::pcrb_resp_t resp,
  output var  logic               feedforwardCapSelect,
  output var  logic [2:0]         rampCode,
  output var  logic [9:0]         rampAmplitude,
  output var  logic               slaveFaultDetectEnable,
  output var  logic               outputDischargeEnable,
  output var  logic               dischargeActive,
  output var  logic [3:0]         powerGoodDelayCode,
  output var  logic [4:0]         powerGoodDelayMs,
  output var  logic [1:0]         feedbackDividerSelect,
  output var  logic               internalDividerSelected
);

  // --------------------------------------------------------------------------
  // Lookup functions
  // --------------------------------------------------------------------------
  // Ramp amplitude in 0.1 mV for a code and phase mode
  function automatic logic [9:0] rampLookup(input logic [2:0] code, input logic multi);
    logic [9:0] val;
    val = `PCRB_RAMP_S0;
    case ({multi, code})
      4'h0:    val = `PCRB_RAMP_S0;
      4'h1:    val = `PCRB_RAMP_S1;
      4'h2:    val = `PCRB_RAMP_S2;
      4'h3:    val = `PCRB_RAMP_S3;
      4'h4:    val = `PCRB_RAMP_S4;
      4'h5:    val = `PCRB_RAMP_S5;
      4'h6:    val = `PCRB_RAMP_S6;
      4'h7:    val = `PCRB_RAMP_S7;
      4'h8:    val = `PCRB_RAMP_M0;
      4'h9:    val = `PCRB_RAMP_M1;
      4'hA:    val = `PCRB_RAMP_M2;
      4'hB:    val = `PCRB_RAMP_M3;
      4'hC:    val = `PCRB_RAMP_M4;
      4'hD:    val = `PCRB_RAMP_M5;
      4'hE:    val = `PCRB_RAMP_M6;
      4'hF:    val = `PCRB_RAMP_M7;
      default: val = `PCRB_RAMP_S0;
    endcase
    return val;
  endfunction

  // Power-good delay in ms for a code
  function automatic logic [4:0] pgDelayLookup(input logic [3:0] code);
    logic [4:0] ms;
    ms = `PCRB_PGD_TOP_MS;
    if (code == `PCRB_PGD_TOP_CODE) begin
      ms = `PCRB_PGD_TOP_MS;
    end else begin
      ms = {1'b0, code} + `PCRB_PGD_OFFSET_MS;
    end
    return ms;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0]           comp_reg;
  logic [7:0]           comp_next;
  logic [7:0]           vout_reg;
  logic [7:0]           vout_next;
  pcrb_pkg::pcrb_resp_t resp_reg;
  pcrb_pkg::pcrb_resp_t resp_next;
  logic [9:0]           ramp_reg;
  logic [9:0]           ramp_next;
  logic                 disch_reg;
  logic                 disch_next;
  logic                 slave_reg;
  logic                 slave_next;
  logic [4:0]           pgms_reg;
  logic [4:0]           pgms_next;
  logic                 intdiv_reg;
  logic                 intdiv_next;
  logic                 reqTaken;

  assign reqTaken = ce & req.valid;

  // Command decode, register update and answer byte
  always_comb begin
    comp_next = comp_reg;
    vout_next = vout_reg;
    resp_next = '0;
    if (reqTaken) begin
      resp_next.valid = 1'b1;
      case (req.code)
        `PCRB_CMD_PROTOCOL_REVISION: begin
          if (req.write) begin
            resp_next.error = 1'b1;
          end else begin
            resp_next.data = {`PCRB_REV_PART_ONE, `PCRB_REV_PART_TWO};
          end
        end
        `PCRB_CMD_LOOP_COMP_CTRL: begin
          if (req.write) begin
            comp_next = req.data; // all eight bits kept
          end else begin
            resp_next.data = comp_reg;
          end
        end
        `PCRB_CMD_OUTPUT_BEHAVIOR: begin
          if (req.write) begin
            vout_next = req.data; // all eight bits kept
          end else begin
            resp_next.data = vout_reg;
          end
        end
        default: begin
          resp_next.error = 1'b1;
        end
      endcase
    end
  end

  // Derived controls follow the new register contents
  always_comb begin
    ramp_next  = rampLookup(comp_next[`PCRB_COMP_RAMP_MSB:`PCRB_COMP_RAMP_LSB], multiPhase);
    disch_next = vout_next[`PCRB_VOUT_DISCH_BIT] & (ctrlPinLow | offCommand);
    // Decoded views are registered so every output leaves a flip-flop
    slave_next  = ~comp_next[`PCRB_COMP_SLAVE_BIT]; // low bit enables
    pgms_next   = pgDelayLookup(vout_next[`PCRB_VOUT_PGD_MSB:`PCRB_VOUT_PGD_LSB]);
    intdiv_next = (vout_next[`PCRB_VOUT_FBDIV_MSB:`PCRB_VOUT_FBDIV_LSB] != `PCRB_FBDIV_EXTERNAL);
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_reg  <= COMP_RESET;
      vout_reg  <= VOUT_RESET;
      resp_reg  <= '0;
      ramp_reg  <= rampLookup(COMP_RESET[`PCRB_COMP_RAMP_MSB:`PCRB_COMP_RAMP_LSB], 1'b0);
      disch_reg <= 1'b0;
      slave_reg  <= ~COMP_RESET[`PCRB_COMP_SLAVE_BIT];
      pgms_reg   <= pgDelayLookup(VOUT_RESET[`PCRB_VOUT_PGD_MSB:`PCRB_VOUT_PGD_LSB]);
      intdiv_reg <= (VOUT_RESET[`PCRB_VOUT_FBDIV_MSB:`PCRB_VOUT_FBDIV_LSB] != `PCRB_FBDIV_EXTERNAL);
    end else if (ce) begin
      comp_reg  <= comp_next;
      vout_reg  <= vout_next;
      resp_reg  <= resp_next;
      ramp_reg  <= ramp_next;
      disch_reg <= disch_next;
      slave_reg  <= slave_next;
      pgms_reg   <= pgms_next;
      intdiv_reg <= intdiv_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Field views of the stored registers
  assign resp                    = resp_reg;
  assign feedforwardCapSelect    = comp_reg[`PCRB_COMP_FFCAP_BIT];
  assign rampCode                = comp_reg[`PCRB_COMP_RAMP_MSB:`PCRB_COMP_RAMP_LSB];
  assign rampAmplitude           = ramp_reg;
  assign slaveFaultDetectEnable  = slave_reg; // low bit enables
  assign outputDischargeEnable   = vout_reg[`PCRB_VOUT_DISCH_BIT];
  assign dischargeActive         = disch_reg;
  assign powerGoodDelayCode      = vout_reg[`PCRB_VOUT_PGD_MSB:`PCRB_VOUT_PGD_LSB];
  assign powerGoodDelayMs        = pgms_reg;
  assign feedbackDividerSelect   = vout_reg[`PCRB_VOUT_FBDIV_MSB:`PCRB_VOUT_FBDIV_LSB];
  assign internalDividerSelected = intdiv_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  rev_read_byte_a: assert property (
    (reqTaken && !req.write && req.code == `PCRB_CMD_PROTOCOL_REVISION)
      |=> (resp.valid && !resp.error) ##1 (!ce || !resp.valid || $past(reqTaken) || !$past(ce)))
    else $error("revision read did not give exactly one byte");

  rev_upper_a: assert property (
    (reqTaken && !req.write && req.code == `PCRB_CMD_PROTOCOL_REVISION) |=> resp.data[7:4] == 4'h3)
    else $error("revision upper nibble wrong");

  rev_lower_a: assert property (
    (reqTaken && !req.write && req.code == `PCRB_CMD_PROTOCOL_REVISION) |=> resp.data[3:0] == 4'h3)
    else $error("revision lower nibble wrong");

  ffcap_follow_a: assert property (
    (reqTaken && req.write && req.code == `PCRB_CMD_LOOP_COMP_CTRL)
      |=> feedforwardCapSelect == $past(req.data[4]))
    else $error("capacitor select not taken from write");

  ramp_single_a: assert property (
    (reqTaken && req.write && req.code == `PCRB_CMD_LOOP_COMP_CTRL && req.data[3:1] == 3'h7 && !multiPhase)
      |=> rampAmplitude == 10'h1B8)
    else $error("single-phase ramp for top code wrong");

  ramp_multi_a: assert property (
    (reqTaken && req.write && req.code == `PCRB_CMD_LOOP_COMP_CTRL && req.data[3:1] == 3'h0 && multiPhase)
      |=> rampAmplitude == 10'h056)
    else $error("multi-phase ramp for code zero wrong");

  slave_detect_a: assert property (
    (reqTaken && req.write && req.code == `PCRB_CMD_LOOP_COMP_CTRL)
      |=> slaveFaultDetectEnable == !$past(req.data[0]))
    else $error("slave fault detection polarity wrong");

  reserved_keep_a: assert property (
    (reqTaken && req.write && req.code == `PCRB_CMD_OUTPUT_BEHAVIOR)
      ##1 (reqTaken && !req.write && req.code == `PCRB_CMD_OUTPUT_BEHAVIOR)
      |=> resp.data == $past(req.data, 2))
    else $error("output register readback differs from write");

  discharge_req_a: assert property (
    (ce && outputDischargeEnable && !(reqTaken && req.write && req.code == `PCRB_CMD_OUTPUT_BEHAVIOR)
      && (ctrlPinLow || offCommand)) |=> dischargeActive)
    else $error("discharge not raised at turn-off");

  power_good_delay_code_a: assert property (
    (powerGoodDelayCode == 4'hF) ? (powerGoodDelayMs == 5'h01)
                                 : (powerGoodDelayMs == {1'b0, powerGoodDelayCode} + 5'h02))
    else $error("power-good delay mapping wrong");

  divider_sel_a: assert property (
    (reqTaken && req.write && req.code == `PCRB_CMD_OUTPUT_BEHAVIOR)
      |=> internalDividerSelected == ($past(req.data[1:0]) != 2'h0))
    else $error("divider selection wrong");

endmodule
`default_nettype wire

// ===== hw/pcrb_params.svh
// Constants for the power module configuration register bank
`ifndef PCRB_PARAMS_SVH
`define PCRB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define PCRB_CMD_PROTOCOL_REVISION 8'h98
`define PCRB_CMD_LOOP_COMP_CTRL    8'hD0
`define PCRB_CMD_OUTPUT_BEHAVIOR   8'hD1

// ----------------------------------------------------------------------------
// Revision byte: part one and part two, both revision 1.3
// ----------------------------------------------------------------------------
`define PCRB_REV_PART_ONE 4'h3
`define PCRB_REV_PART_TWO 4'h3

// ----------------------------------------------------------------------------
// Loop compensation fields
// ----------------------------------------------------------------------------
`define PCRB_COMP_FFCAP_BIT   4
`define PCRB_COMP_RAMP_MSB    3
`define PCRB_COMP_RAMP_LSB    1
`define PCRB_COMP_SLAVE_BIT   0

// ----------------------------------------------------------------------------
// Output behaviour fields
// ----------------------------------------------------------------------------
`define PCRB_VOUT_DISCH_BIT   6
`define PCRB_VOUT_PGD_MSB     5
`define PCRB_VOUT_PGD_LSB     2
`define PCRB_VOUT_FBDIV_MSB   1
`define PCRB_VOUT_FBDIV_LSB   0
`define PCRB_FBDIV_EXTERNAL   2'h0

// ----------------------------------------------------------------------------
// Power-good delay in ms: code plus offset, top code wraps to the shortest
// ----------------------------------------------------------------------------
`define PCRB_PGD_OFFSET_MS    5'h02
`define PCRB_PGD_TOP_CODE     4'hF
`define PCRB_PGD_TOP_MS       5'h01

// ----------------------------------------------------------------------------
// Ramp amplitude in units of 0.1 mV
// ----------------------------------------------------------------------------
`define PCRB_RAMP_S0 10'h038
`define PCRB_RAMP_S1 10'h062
`define PCRB_RAMP_S2 10'h0B4
`define PCRB_RAMP_S3 10'h12C
`define PCRB_RAMP_S4 10'h055
`define PCRB_RAMP_S5 10'h097
`define PCRB_RAMP_S6 10'h10E
`define PCRB_RAMP_S7 10'h1B8
`define PCRB_RAMP_M0 10'h056
`define PCRB_RAMP_M1 10'h096
`define PCRB_RAMP_M2 10'h10E
`define PCRB_RAMP_M3 10'h1C2
`define PCRB_RAMP_M4 10'h082
`define PCRB_RAMP_M5 10'h0E6
`define PCRB_RAMP_M6 10'h19A
`define PCRB_RAMP_M7 10'h2A8

`define PCRB_RESET_BYTE 8'h00

`endif

// ===== hw/pcrb_pkg.sv
// Types shared by the configuration register bank
package pcrb_pkg;

  // --------------------------------------------------------------------------
  // Command request and answer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } pcrb_req_t;

  typedef struct packed {
    logic       valid;
    logic       error;
    logic [7:0] data;
  } pcrb_resp_t;

endpackage

// ===== testbench/pcrb_host_model.sv
// Host model that issues single-byte command transfers to the register bank
`timescale 1ns/10ps
`default_nettype none
module pcrb_host_model (
  input  wire logic                 clk,
  output var  pcrb_pkg::pcrb_req_t  req,
  input  wire pcrb_pkg::pcrb_resp_t resp
);
  // --------------------------------------------------------------------------
  // Transfer: request held over the taking edge, answer read while it stands
  // --------------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                      output pcrb_pkg::pcrb_resp_t r);
    req = {1'b1, wr, code, data};
    @(posedge clk);
    #1 req = {1'b0, ~wr, ~code, ~data}; // Released fields show inverted values
    r = resp; // answer stands only in the cycle after the taking edge
    @(posedge clk);
    #1;
  endtask

  // Write then read back in consecutive cycles, valid held high between them
  task automatic xfer_pair(input logic [7:0] code, input logic [7:0] data,
                           output pcrb_pkg::pcrb_resp_t r);
    req = {1'b1, 1'b1, code, data};
    @(posedge clk);
    #1 req = {1'b1, 1'b0, code, ~data}; // Read follows at once
    @(posedge clk);
    #1 req = {1'b0, 1'b1, ~code, data};
    r = resp;
    @(posedge clk);
    #1;
  endtask

  // Idle bus before the first transfer
  initial req = '0;
endmodule
`default_nettype wire

// ===== testbench/pmbus_config_register_bank_tb.sv
// Self-checking testbench of the configuration register bank
`timescale 1ns/10ps
`default_nettype none
module pmbus_config_register_bank_tb;
  logic                 clk, nrst, ce, multiPhase, ctrlPinLow, offCommand;
  logic                 ffCap, slaveEn, disEn, disAct, intDiv;
  logic [2:0]           ramp;
  logic [9:0]           rampAmp;
  logic [3:0]           pgdCode;
  logic [4:0]           pgdMs;
  logic [1:0]           fbDiv;
  pcrb_pkg::pcrb_req_t  req;
  pcrb_pkg::pcrb_resp_t resp, r;
  int                   fails, total_checks;
  // Ramp in 0.1 mV: single-phase codes 0..7, then multi-phase codes 0..7
  logic [9:0]           rampTab [16] = '{10'h038, 10'h062, 10'h0B4, 10'h12C, 10'h055, 10'h097, 10'h10E,
    10'h1B8, 10'h056, 10'h096, 10'h10E, 10'h1C2, 10'h082, 10'h0E6, 10'h19A, 10'h2A8};

  // --------------------------------------------------------------------------
  // Design, host and clock
  // --------------------------------------------------------------------------
  pcrb_register_bank dut (.clk(clk), .nrst(nrst), .ce(ce), .req(req), .multiPhase(multiPhase),
    .ctrlPinLow(ctrlPinLow), .offCommand(offCommand), .resp(resp), .feedforwardCapSelect(ffCap),
    .rampCode(ramp), .rampAmplitude(rampAmp), .slaveFaultDetectEnable(slaveEn),
    .outputDischargeEnable(disEn), .dischargeActive(disAct), .powerGoodDelayCode(pgdCode),
    .powerGoodDelayMs(pgdMs), .feedbackDividerSelect(fbDiv), .internalDividerSelected(intDiv));
  pcrb_host_model host (.clk(clk), .req(req), .resp(resp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Compare and closing
  // --------------------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Revision reads, refused write to the read-only code
  task automatic t_rev();
    host.xfer(1'b0, 8'h98, 8'h00, r);
    chk(r, {2'b10, 8'h33});
    host.xfer(1'b1, 8'h98, 8'h5A, r);
    chk(r, {2'b11, 8'h00});
    host.xfer(1'b0, 8'h98, 8'h00, r);
    chk(r, {2'b10, 8'h33});
    $display("test revision done");
  endtask

  // Every ramp code in both phase modes, all compensation fields
  task automatic t_comp();
    logic [3:0] k;
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      d = {~k[2:0], k[0] ^ k[1], k[2:0], k[1]};
      multiPhase = k[3];
      host.xfer(1'b1, 8'hD0, d, r);
      chk(r, {2'b10, 8'h00});
      @(posedge clk);
      #1 chk(ffCap, k[0] ^ k[1]);
      chk(ramp, k[2:0]);
      chk(rampAmp, rampTab[k]);
      chk(slaveEn, !k[1]);
      host.xfer(1'b0, 8'hD0, 8'h00, r);
      chk(r, {2'b10, d});
    end
    $display("test compensation done");
  endtask

  // Every power-good delay code, divider choices and reserved bit
  task automatic t_vout();
    logic [3:0] k;
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      d = {k[1], k[0], k, k[1:0]};
      host.xfer(1'b1, 8'hD1, d, r);
      chk(r, {2'b10, 8'h00});
      chk(disEn, k[0]);
      chk(pgdCode, k);
      chk(pgdMs, (k == 4'hF) ? 5'h01 : {1'b0, k} + 5'h02);
      chk(fbDiv, k[1:0]);
      chk(intDiv, k[1:0] != 2'h0);
      host.xfer(1'b0, 8'hD1, 8'h00, r);
      chk(r, {2'b10, d});
    end
    $display("test output behaviour done");
  endtask

  // Discharge by control pin and by off command, then disabled
  task automatic t_dis();
    host.xfer(1'b1, 8'hD1, 8'h40, r);
    ctrlPinLow = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(disAct, 1'b1);
    ctrlPinLow = 1'b0;
    offCommand = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(disAct, 1'b1);
    host.xfer(1'b1, 8'hD1, 8'h00, r);
    repeat (2) @(posedge clk);
    #1 chk(disAct, 1'b0);
    offCommand = 1'b0;
    $display("test discharge done");
  endtask

  // Unmapped codes refused, nothing taken while the clock enable is low
  task automatic t_misc();
    host.xfer(1'b0, 8'hD2, 8'h00, r);
    chk(r, {2'b11, 8'h00});
    host.xfer(1'b1, 8'h00, 8'h12, r);
    chk(r, {2'b11, 8'h00});
    host.xfer(1'b1, 8'hD0, 8'hA5, r);
    chk(r, {2'b10, 8'h00});
    ce = 1'b0;
    host.xfer(1'b1, 8'hD0, 8'hFF, r);
    ce = 1'b1;
    host.xfer(1'b0, 8'hD0, 8'h00, r);
    chk(r, {2'b10, 8'hA5});
    host.xfer_pair(8'hD1, 8'hC3, r);
    chk(r, {2'b10, 8'hC3});
    $display("test refusal and enable done");
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    fails = 0;
    total_checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    multiPhase = 1'b0;
    ctrlPinLow = 1'b0;
    offCommand = 1'b0;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    t_rev();
    t_comp();
    t_vout();
    t_dis();
    t_misc();
    test_done();
  end

  initial begin
    #100000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
